// file: core/general_config_registers.sv
// General configuration register bank with SPI access and host clock divider
`include "gcr_defs.svh"
module general_config_registers
(
  input  logic                   I_CLK,
  input  logic                   I_RESET_N,
  input  logic                   I_SPI_CS_N,
  input  logic                   I_SPI_SCLK,
  input  logic                   I_SPI_MOSI,
  output logic                   O_SPI_MISO,
  output logic                   O_SPI_MISO_OE,
  input  logic                   I_RC_CLK,
  input  logic                   I_SLEEP,
  input  logic                   I_STANDBY,
  output gcr_pkg::bld_level_e    O_BATTERY_THRESHOLD_SELECT,
  output logic [2:0]             O_CRYSTAL_STARTUP_DRIVE,
  output logic                   O_CRYSTAL_FREQUENCY_SELECT,
  output logic                   O_AES_ENABLE,
  output logic                   O_REFERENCE_SOURCE_SELECT,
  output logic                   O_UNDERVOLTAGE_DETECT_ENABLE,
  output logic                   O_LOW_BATTERY_DETECTOR_ENABLE,
  output logic                   O_TEMPERATURE_SENSOR_ENABLE,
  output logic [19:0]            O_PIN_SELECT,
  output logic [7:0]             O_PIN_MODE,
  output logic                   O_PIN0_ANALOG,
  output logic                   O_CLOCK_DIVIDER_POWERDOWN,
  output logic                   O_HOST_CLK_TICK,
  output logic                   O_HOST_CLK_SOURCE_RC,
  output logic                   O_STANDBY_NOTICE
);
  import gcr_pkg::*;

  // Bit 3 flags a mapped address, low bits index the store
  function automatic logic [3:0] reg_index(input logic [7:0] a);
    unique case (a)
      `ADDR_ANALOG_HI:  reg_index = 4'h8;
      `ADDR_ANALOG_LO:  reg_index = 4'h9;
      `ADDR_PIN3:       reg_index = 4'hA;
      `ADDR_PIN2:       reg_index = 4'hB;
      `ADDR_PIN1:       reg_index = 4'hC;
      `ADDR_PIN0:       reg_index = 4'hD;
      `ADDR_HOST_CLOCK: reg_index = 4'hE;
      `ADDR_OSC_TEST:   reg_index = 4'hF;
      default:          reg_index = 4'h0;
    endcase
  endfunction

  // Denominator of the crystal ratio; numerator is 2 only for code 1
  function automatic logic [7:0] xo_den(input logic [3:0] code);
    unique case (code)
      4'h0: xo_den = 8'h01;
      4'h1: xo_den = 8'h03;
      4'h2: xo_den = 8'h02;
      4'h3: xo_den = 8'h03;
      4'h4: xo_den = 8'h04;
      4'h5: xo_den = 8'h06;
      4'h6: xo_den = 8'h08;
      4'h7: xo_den = 8'h0C;
      4'h8: xo_den = 8'h10;
      4'h9: xo_den = 8'h18;
      4'hA: xo_den = 8'h24;
      4'hB: xo_den = 8'h30;
      4'hC: xo_den = 8'h40;
      4'hD: xo_den = 8'h60;
      4'hE: xo_den = 8'h80;
      4'hF: xo_den = 8'hC0;
    endcase
  endfunction

  // Pins: 0 chip select, 1 serial clock, 2 serial data in, 3 RC clock
  logic [3:0] sync1, sync2, sync3, filt, next_filt;
  logic [7:0] cfg [0:7];
  logic [7:0] next_cfg [0:7];
  logic [2:0] bit_cnt, next_bit_cnt;
  logic [1:0] byte_cnt, next_byte_cnt;
  logic [7:0] shift_in, next_shift_in, shift_out, next_shift_out, addr, next_addr;
  logic       is_read, next_is_read, is_valid, next_is_valid, miso, next_miso;
  logic       tail_flag, next_tail_flag;
  logic       sclk_rise, sclk_fall, byte_done, commit, rd_load;
  logic [7:0] rd_addr, rd_data, sin;
  logic [3:0] rd_idx, wr_idx;

  always_comb
  begin
    for (int i = 0; i < 4; i++)
      next_filt[i] = (sync2[i] == sync3[i]) ? sync2[i] : filt[i];
  end

  assign sclk_rise = !filt[0] && next_filt[1] && !filt[1];
  assign sclk_fall = !filt[0] && !next_filt[1] && filt[1];
  assign sin       = {shift_in[6:0], filt[2]};
  assign byte_done = sclk_rise && (bit_cnt == 3'h7);
  assign commit    = byte_done && (byte_cnt == 2'h2) && is_valid && !is_read;
  assign rd_load   = byte_done && is_valid && is_read && (byte_cnt != 2'h0);
  assign rd_addr   = (byte_cnt == 2'h1) ? sin : addr + 8'h01;
  assign rd_idx    = reg_index(rd_addr);
  assign wr_idx    = reg_index(addr);

  always_comb
  begin
    rd_data = 8'h00;
    if (rd_idx[3])
      rd_data = cfg[rd_idx[2:0]];
    else if (rd_addr == `ADDR_TAIL_STATUS)
      rd_data = {7'h00, tail_flag};
  end

  logic       rc_rise, src_rc, next_src_rc, standby_q, notice, next_notice;
  logic       tick_q, next_tick, gen, allowed, enter;
  logic [7:0] acc, next_acc, acc_sum, den;
  logic [6:0] rc_cnt, next_rc_cnt;
  logic [9:0] tail_cnt, next_tail_cnt;
  tail_e      tail_state, next_tail_state;

  always_comb
  begin
    next_bit_cnt   = bit_cnt;
    next_byte_cnt  = byte_cnt;
    next_shift_in  = shift_in;
    next_shift_out = shift_out;
    next_addr      = addr;
    next_is_read   = is_read;
    next_is_valid  = is_valid;
    next_miso      = miso;
    next_cfg       = cfg;
    next_tail_flag = tail_flag;
    if (filt[0])
    begin
      next_bit_cnt  = 3'h0;
      next_byte_cnt = 2'h0;
    end
    else if (sclk_rise)
    begin
      next_shift_in = sin;
      next_bit_cnt  = bit_cnt + 3'h1;
      if (byte_done)
      begin
        if (byte_cnt != 2'h2)
          next_byte_cnt = byte_cnt + 2'h1;
        unique case (byte_cnt)
          2'h0:
          begin
            next_is_read  = (sin == `SPI_HDR_READ);
            next_is_valid = (sin == `SPI_HDR_READ) || (sin == `SPI_HDR_WRITE);
          end
          2'h1:    next_addr = sin;
          default: next_addr = addr + 8'h01;
        endcase
        if (rd_load)
          next_shift_out = rd_data;
      end
    end
    else if (sclk_fall)
    begin
      next_miso      = shift_out[7];
      next_shift_out = {shift_out[6:0], 1'b0};
    end
    if (commit && wr_idx[3])
      next_cfg[wr_idx[2:0]] = sin;
    // Status ignores writes; a read clears it, but a new event wins
    if (rd_load && rd_addr == `ADDR_TAIL_STATUS)
      next_tail_flag = 1'b0;
    if (enter)
      next_tail_flag = 1'b1;
  end

  always_ff @(posedge I_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      // Idle levels: select high, serial clock low, so no false edge follows reset
      sync1     <= 4'h1;
      sync2     <= 4'h1;
      sync3     <= 4'h1;
      filt      <= 4'h1;
      bit_cnt   <= 3'h0;
      byte_cnt  <= 2'h0;
      shift_in  <= 8'h00;
      shift_out <= 8'h00;
      addr      <= 8'h00;
      is_read   <= 1'b0;
      is_valid  <= 1'b0;
      miso      <= 1'b0;
      tail_flag <= 1'b0;
      cfg[0]    <= `RST_ANALOG_HI;
      cfg[1]    <= `RST_ANALOG_LO;
      cfg[2]    <= `RST_PIN_GROUND;
      cfg[3]    <= `RST_PIN_GROUND;
      cfg[4]    <= `RST_PIN_GROUND;
      cfg[5]    <= `RST_PIN0;
      cfg[6]    <= `RST_HOST_CLOCK;
      cfg[7]    <= `RST_OSC_TEST;
    end
    else
    begin
      sync1     <= {I_RC_CLK, I_SPI_MOSI, I_SPI_SCLK, I_SPI_CS_N};
      sync2     <= sync1;
      sync3     <= sync2;
      filt      <= next_filt;
      bit_cnt   <= next_bit_cnt;
      byte_cnt  <= next_byte_cnt;
      shift_in  <= next_shift_in;
      shift_out <= next_shift_out;
      addr      <= next_addr;
      is_read   <= next_is_read;
      is_valid  <= next_is_valid;
      miso      <= next_miso;
      tail_flag <= next_tail_flag;
      cfg       <= next_cfg;
    end
  end

  // Host clock: one tick per host clock period, fractional ratios by accumulation
  assign rc_rise = next_filt[3] && !filt[3];
  assign den     = xo_den(cfg[6][`HCK_RATIO_MSB:`HCK_RATIO_LSB]);
  assign acc_sum = acc + ((cfg[6][`HCK_RATIO_MSB:`HCK_RATIO_LSB] == 4'h1) ? 8'h02 : 8'h01);
  assign allowed = cfg[6][`HCK_EN_BIT]
                   && !cfg[7][`OSC_PD_BIT] && (tail_state != TAIL_STOP);
  assign enter   = I_STANDBY && !standby_q && (tail_state == TAIL_RUN);

  always_comb
  begin
    next_acc        = acc;
    next_rc_cnt     = rc_cnt;
    next_src_rc     = src_rc;
    next_tail_cnt   = tail_cnt;
    next_tail_state = tail_state;
    next_notice     = enter;
    gen             = 1'b0;
    // Source only swaps on an RC edge so the host never sees a runt pulse
    if (rc_rise)
      next_src_rc = I_SLEEP;
    if (!cfg[7][`OSC_PD_BIT])
    begin
      if (!src_rc)
      begin
        gen      = (acc_sum >= den);
        next_acc = gen ? acc_sum - den : acc_sum;
      end
      else if (rc_rise)
      begin
        gen         = !cfg[6][`HCK_RC_BIT] || (rc_cnt == `RC_DIV_LAST);
        next_rc_cnt = rc_cnt + 7'h01;
      end
    end
    next_tick = gen && allowed;
    unique case (tail_state)
      TAIL_RUN:
        if (enter)
        begin
          unique case (cfg[6][`HCK_TAIL_MSB:`HCK_TAIL_LSB])
            2'h0: next_tail_cnt = 10'h000;
            2'h1: next_tail_cnt = `TAIL_CNT_64;
            2'h2: next_tail_cnt = `TAIL_CNT_256;
            2'h3: next_tail_cnt = `TAIL_CNT_512;
          endcase
          next_tail_state = (cfg[6][`HCK_TAIL_MSB:`HCK_TAIL_LSB] == 2'h0) ? TAIL_STOP
                                                                           : TAIL_COUNT;
        end
      TAIL_COUNT:
        if (!I_STANDBY)
          next_tail_state = TAIL_RUN;
        else if (next_tick)
        begin
          next_tail_cnt = tail_cnt - 10'h001;
          if (tail_cnt == 10'h001)
            next_tail_state = TAIL_STOP;
        end
      TAIL_STOP:
        if (!I_STANDBY)
          next_tail_state = TAIL_RUN;
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      acc        <= 8'h00;
      rc_cnt     <= 7'h00;
      src_rc     <= 1'b0;
      standby_q  <= 1'b0;
      notice     <= 1'b0;
      tick_q     <= 1'b0;
      tail_cnt   <= 10'h000;
      tail_state <= TAIL_RUN;
    end
    else
    begin
      acc        <= next_acc;
      rc_cnt     <= next_rc_cnt;
      src_rc     <= next_src_rc;
      standby_q  <= I_STANDBY;
      notice     <= next_notice;
      tick_q     <= next_tick;
      tail_cnt   <= next_tail_cnt;
      tail_state <= next_tail_state;
    end
  end

  assign O_SPI_MISO                    = miso;
  assign O_SPI_MISO_OE                 = !filt[0];
  assign O_BATTERY_THRESHOLD_SELECT    = bld_level_e'(cfg[0][1:0]);
  assign O_CRYSTAL_STARTUP_DRIVE       = cfg[0][4:2];
  assign O_CRYSTAL_FREQUENCY_SELECT    = cfg[1][6];
  assign O_AES_ENABLE                  = cfg[1][5];
  assign O_REFERENCE_SOURCE_SELECT     = cfg[1][4];
  assign O_UNDERVOLTAGE_DETECT_ENABLE  = cfg[1][2];
  assign O_LOW_BATTERY_DETECTOR_ENABLE = cfg[1][1];
  assign O_TEMPERATURE_SENSOR_ENABLE   = cfg[1][0];
  assign O_PIN_SELECT  = {cfg[2][7:3], cfg[3][7:3], cfg[4][7:3], cfg[5][7:3]};
  assign O_PIN_MODE    = {cfg[2][1:0], cfg[3][1:0], cfg[4][1:0], cfg[5][1:0]};
  assign O_PIN0_ANALOG = (cfg[5][1:0] == `PIN_MODE_ANALOG);
  assign O_CLOCK_DIVIDER_POWERDOWN     = cfg[7][`OSC_PD_BIT];
  assign O_HOST_CLK_TICK               = tick_q;
  assign O_HOST_CLK_SOURCE_RC          = src_rc;
  assign O_STANDBY_NOTICE              = notice;

  property p_rr_clear;
    @(posedge I_CLK) disable iff (!I_RESET_N)
      rd_load && rd_addr == `ADDR_TAIL_STATUS && !enter |=> !tail_flag;
  endproperty
  a_rr_clear: assert property (p_rr_clear) else $error("status not cleared by read");
  property p_write;
    @(posedge I_CLK) disable iff (!I_RESET_N)
      commit && addr == `ADDR_HOST_CLOCK |=> cfg[6] == $past(sin);
  endproperty
  a_write: assert property (p_write) else $error("write did not land");
  property p_pd_stop;
    @(posedge I_CLK) disable iff (!I_RESET_N)
      cfg[7][`OSC_PD_BIT] |=> !O_HOST_CLK_TICK;
  endproperty
  a_pd_stop: assert property (p_pd_stop) else $error("tick while dividers down");
  property p_en_off;
    @(posedge I_CLK) disable iff (!I_RESET_N)
      !cfg[6][`HCK_EN_BIT] |=> !O_HOST_CLK_TICK;
  endproperty
  a_en_off: assert property (p_en_off) else $error("tick while host clock off");
  property p_ratio_one;
    @(posedge I_CLK) disable iff (!I_RESET_N)
      allowed && !src_rc && cfg[6][4:1] == 4'h0 |=> O_HOST_CLK_TICK;
  endproperty
  a_ratio_one: assert property (p_ratio_one) else $error("ratio 1 missed a tick");
  property p_src_edge;
    @(posedge I_CLK) disable iff (!I_RESET_N)
      $changed(src_rc) |-> $past(rc_rise);
  endproperty
  a_src_edge: assert property (p_src_edge) else $error("source switched off RC edge");
  property p_notice;
    @(posedge I_CLK) disable iff (!I_RESET_N)
      enter |=> O_STANDBY_NOTICE ##1 !O_STANDBY_NOTICE;
  endproperty
  a_notice: assert property (p_notice) else $error("standby notice missing");
  property p_tail_none;
    @(posedge I_CLK) disable iff (!I_RESET_N)
      enter && cfg[6][6:5] == 2'h0 |=> ##1 !O_HOST_CLK_TICK [*3];
  endproperty
  a_tail_none: assert property (p_tail_none) else $error("tick after zero tail");
  property p_unmapped;
    @(posedge I_CLK) disable iff (!I_RESET_N)
      rd_load && !rd_idx[3] && rd_addr != `ADDR_TAIL_STATUS |=> shift_out == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule

// file: pkg/gcr_defs.svh
// Offsets, reset values, field positions and counts of the general configuration bank
`ifndef GCR_DEFS_SVH
`define GCR_DEFS_SVH
`define ADDR_ANALOG_HI      8'h00
`define ADDR_ANALOG_LO      8'h01
`define ADDR_PIN3           8'h02
`define ADDR_PIN2           8'h03
`define ADDR_PIN1           8'h04
`define ADDR_PIN0           8'h05
`define ADDR_HOST_CLOCK     8'h06
`define ADDR_OSC_TEST       8'hB4
`define ADDR_TAIL_STATUS    8'hC0
`define RST_ANALOG_HI       8'h0C
`define RST_ANALOG_LO       8'hC0
`define RST_PIN_GROUND      8'hA2
`define RST_PIN0            8'h0A
`define RST_HOST_CLOCK      8'h00
`define RST_OSC_TEST        8'h21
`define SPI_HDR_WRITE       8'h00
`define SPI_HDR_READ        8'h01
`define HCK_EN_BIT          7
`define HCK_TAIL_MSB        6
`define HCK_TAIL_LSB        5
`define HCK_RATIO_MSB       4
`define HCK_RATIO_LSB       1
`define HCK_RC_BIT          0
`define OSC_PD_BIT          3
`define PIN_MODE_ANALOG     2'h0
`define TAIL_CNT_64         10'h040
`define TAIL_CNT_256        10'h100
`define TAIL_CNT_512        10'h200
`define RC_DIV_LAST         7'h7F
`endif

// file: pkg/gcr_pkg.sv
// Types shared by the general configuration bank
package gcr_pkg;
  typedef enum logic [1:0]
  {
    BLD_2V7 = 2'h0,
    BLD_2V5 = 2'h1,
    BLD_2V3 = 2'h2,
    BLD_2V1 = 2'h3
  } bld_level_e;
  typedef enum {TAIL_RUN, TAIL_COUNT, TAIL_STOP} tail_e;
  typedef logic [7:0] reg_t;
endpackage

// file: testbench/spi_host_model.sv
// Host side SPI master model for the configuration port
module spi_host_model
(
  input  wire logic i_clk,
  output logic      o_cs_n,
  output logic      o_sclk,
  output logic      o_mosi,
  input  wire logic i_miso
);
  timeunit 1ns;
  timeprecision 1ps;
  // Half period well above the design's filter delay
  localparam int HALF = 8;
  initial
  begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_mosi = 1'b0;
  end
  task automatic tick_n(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  // Header, address and one data byte, mode 0, MSB first
  task automatic frame(input logic [7:0] hdr, input logic [7:0] addr,
                       input logic [7:0] wdat, output logic [7:0] rdat);
    logic [23:0] sh;
    sh = {hdr, addr, wdat};
    rdat = 8'h00;
    tick_n(1);
    o_cs_n = 1'b0;
    tick_n(HALF);
    for (int i = 23; i >= 0; i--)
    begin
      o_mosi = sh[i];
      tick_n(HALF);
      o_sclk = 1'b1;
      if (i < 8)
        rdat = {rdat[6:0], i_miso};
      tick_n(HALF);
      o_sclk = 1'b0;
    end
    tick_n(HALF);
    o_cs_n = 1'b1;
    // Idle data line must not look like a valid last bit
    o_mosi = ~o_mosi;
    tick_n(HALF);
  endtask
endmodule

// file: testbench/testbench.sv
// Self-checking bench for the general configuration register bank
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import gcr_pkg::*;
  localparam int LIMIT = 80000;
  logic       clk, rst_n, sleep, standby, rc_clk, cs_n, sclk, mosi, miso;
  logic       miso_oe, miso_bus;
  logic       freq, aes, refsel, uv, batt, temp, pin0_an, pd, tick, src_rc, notice;
  logic [2:0] rc_cnt = 3'h0;
  logic [2:0] drive;
  logic [19:0] pin_sel;
  logic [7:0] pin_mode;
  bld_level_e low_battery_detector;
  int         err_total, checks_done, ticks, notices, cycles;
  logic [7:0] addrs [8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'hB4};
  logic [7:0] rstv [8] = '{8'h0C, 8'hC0, 8'hA2, 8'hA2, 8'hA2, 8'h0A, 8'h00, 8'h21};
  int         xo_tk [16] = '{1152, 768, 576, 384, 288, 192, 144, 96, 72, 48, 32, 24, 18, 12, 9, 6};
  int         tail [4] = '{0, 64, 256, 512};
  // Released line reads as the inverse, so a sample outside the drive window fails
  assign miso_bus = miso_oe ? miso : ~miso;
  spi_host_model host (.i_clk(clk), .o_cs_n(cs_n), .o_sclk(sclk), .o_mosi(mosi),
                       .i_miso(miso_bus));
  general_config_registers dut
  (
    .I_CLK(clk), .I_RESET_N(rst_n), .I_SPI_CS_N(cs_n), .I_SPI_SCLK(sclk), .I_SPI_MOSI(mosi),
    .O_SPI_MISO(miso), .O_SPI_MISO_OE(miso_oe), .I_RC_CLK(rc_clk), .I_SLEEP(sleep),
    .I_STANDBY(standby), .O_BATTERY_THRESHOLD_SELECT(low_battery_detector), .O_CRYSTAL_STARTUP_DRIVE(drive),
    .O_CRYSTAL_FREQUENCY_SELECT(freq), .O_AES_ENABLE(aes), .O_REFERENCE_SOURCE_SELECT(refsel),
    .O_UNDERVOLTAGE_DETECT_ENABLE(uv), .O_LOW_BATTERY_DETECTOR_ENABLE(batt),
    .O_TEMPERATURE_SENSOR_ENABLE(temp), .O_PIN_SELECT(pin_sel), .O_PIN_MODE(pin_mode),
    .O_PIN0_ANALOG(pin0_an), .O_CLOCK_DIVIDER_POWERDOWN(pd), .O_HOST_CLK_TICK(tick),
    .O_HOST_CLK_SOURCE_RC(src_rc), .O_STANDBY_NOTICE(notice)
  );
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // RC clock of eight digital cycles, changed off the sampling edge
  always @(negedge clk)
  begin
    rc_cnt <= rc_cnt + 3'h1;
    rc_clk <= rc_cnt[2];
  end
  always @(posedge clk)
  begin
    if (tick === 1'b1)
      ticks++;
    if (notice === 1'b1)
      notices++;
    cycles++;
    if (cycles == LIMIT)
    begin
      err_total++;
      $display("MISMATCH run_length expected %0d seen %0d", LIMIT - 1, cycles);
      wrap_up();
    end
  end
  task automatic wrap_up;
    $display("Comparisons %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Tick windows have unknown phase, so allow a small slack
  task automatic near(input string what, input int n, input int e, input int tol);
    check(what, 32'(n), (n >= e - tol && n <= e + tol) ? 32'(n) : 32'(e));
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] x;
    host.frame(8'h00, a, d, x);
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.frame(8'h01, a, 8'h00, d);
    check(what, 32'(d), 32'(e));
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic do_reset;
    rst_n = 1'b0;
    cyc(5);
    rst_n = 1'b1;
    cyc(4);
  endtask
  initial
  begin
    logic [7:0] v, x;
    sleep = 1'b0;
    standby = 1'b0;
    do_reset();
    for (int i = 0; i < 8; i++)
      rd_chk("reset_value", addrs[i], rstv[i]);
    check("bld", 32'(low_battery_detector), 32'(BLD_2V7));
    check("pins", 32'({pin_sel, pin_mode}), 32'({20'hA5281, 8'hAA}));
    check("miso_oe", 32'(miso_oe), 32'h0);
    $display("test reset done");
    for (int c = 0; c < 4; c++)
    begin
      v = {3'b000, 3'(2 * c + 1), 2'(c)};
      wr(8'h00, v);
      check("bld", 32'(low_battery_detector), 32'(c));
      check("drive", 32'(drive), 32'(2 * c + 1));
      rd_chk("analog_hi", 8'h00, v);
    end
    host.frame(8'h02, 8'h00, 8'h00, x);
    rd_chk("bad_header", 8'h00, 8'h1F);
    wr(8'h01, 8'hB7);
    check("analog_lo", 32'({freq, aes, refsel, uv, batt, temp}), 32'h1F);
    rd_chk("analog_lo", 8'h01, 8'hB7);
    wr(8'h01, 8'hC0);
    check("analog_lo", 32'({freq, aes, refsel, uv, batt, temp}), 32'h20);
    wr(8'hC0, 8'hFF);
    rd_chk("status_ro", 8'hC0, 8'h00);
    wr(8'h10, 8'h55);
    rd_chk("unmapped", 8'h10, 8'h00);
    $display("test analog done");
    for (int m = 0; m < 4; m++)
    begin
      wr(8'h05, {5'h13, 1'b0, 2'(m)});
      wr(8'h02, {5'h0B, 1'b0, 2'(m | 1)});
      check("mode", 32'({pin_mode[7:6], pin_mode[1:0]}), 32'({2'(m | 1), 2'(m)}));
      check("analog", 32'(pin0_an), 32'(m == 0));
    end
    check("select", 32'(pin_sel), {12'h0, 5'h0B, 5'h14, 5'h14, 5'h13});
    $display("test pins done");
    wr(8'h06, 8'h80);
    wr(8'hB4, 8'h29);
    check("powerdown", 32'(pd), 32'h1);
    ticks = 0;
    cyc(100);
    check("stopped", 32'(ticks), 32'h0);
    wr(8'hB4, 8'h21);
    check("powerdown", 32'(pd), 32'h0);
    for (int c = 0; c < 16; c++)
    begin
      wr(8'h06, {1'b1, 2'b00, 4'(c), 1'b0});
      cyc(20);
      ticks = 0;
      cyc(1152);
      near("xo_ticks", ticks, xo_tk[c], 1);
    end
    wr(8'h06, 8'h00);
    ticks = 0;
    cyc(100);
    check("disabled", 32'(ticks), 32'h0);
    $display("test xo done");
    wr(8'h06, 8'h80);
    sleep = 1'b1;
    cyc(30);
    check("source", 32'(src_rc), 32'h1);
    ticks = 0;
    cyc(800);
    near("rc_ticks", ticks, 100, 1);
    wr(8'h06, 8'h81);
    cyc(20);
    ticks = 0;
    cyc(4096);
    near("rc_ticks", ticks, 4, 1);
    sleep = 1'b0;
    cyc(30);
    check("source", 32'(src_rc), 32'h0);
    $display("test rc done");
    for (int t = 0; t < 4; t++)
    begin
      wr(8'h06, {1'b1, 2'(t), 5'h00});
      cyc(10);
      ticks = 0;
      notices = 0;
      standby = 1'b1;
      cyc(3);
      check("notice", 32'(notices), 32'h1);
      cyc(600);
      near("tail", ticks, tail[t], 2);
      check("notice", 32'(notices), 32'h1);
      rd_chk("status", 8'hC0, 8'h01);
      rd_chk("status", 8'hC0, 8'h00);
      standby = 1'b0;
      cyc(20);
    end
    $display("test standby done");
    wr(8'h01, 8'hB7);
    standby = 1'b1;
    cyc(5);
    standby = 1'b0;
    do_reset();
    for (int i = 0; i < 8; i++)
      rd_chk("rereset_value", addrs[i], rstv[i]);
    rd_chk("rereset_status", 8'hC0, 8'h00);
    $display("test rereset done");
    wrap_up();
  end
endmodule
